// file: src/nvs_pkg.sv
// Package: constants, register map and bus carriers for the nonvolatile access block
package nvs_pkg;
    // Timing
    localparam int NVS_CLK_MHZ = 100;
    localparam int NVS_T_PROG_US = 2000;
    localparam int NVS_T_PWRT_MS = 64;
    localparam int NVS_PROG_CYC = NVS_T_PROG_US * NVS_CLK_MHZ;
    localparam int NVS_PWRT_CYC = NVS_T_PWRT_MS * 1000 * NVS_CLK_MHZ;
    localparam logic [22:0] NVS_SETUP_LAST = 23'h000001;
    localparam logic [22:0] NVS_PRD_STALL = 23'h000001;
    localparam int NVS_CNT_W = 23;
    // Memory geometry
    localparam int NVS_EE_WORDS = 256;
    localparam int NVS_PM_AW = 15;
    localparam int NVS_ROW_AW = 4;
    localparam int NVS_ROW_WORDS = 16;
    localparam logic [13:0] NVS_ERASED = 14'h3fff;
    // Self-write protect segments
    localparam logic [1:0] NVS_WP_NONE = 2'h3;
    localparam logic [1:0] NVS_WP_LOW = 2'h2;
    localparam logic [1:0] NVS_WP_HALF = 2'h1;
    localparam logic [14:0] NVS_WP_LOW_END = 15'h0200;
    localparam logic [14:0] NVS_WP_HALF_END = 15'h0400;
    // Register word indices (byte address = index * 4)
    localparam logic [2:0] NVS_IDX_ADDR_LO = 3'h0;
    localparam logic [2:0] NVS_IDX_ADDR_HI = 3'h1;
    localparam logic [2:0] NVS_IDX_DATA_LO = 3'h2;
    localparam logic [2:0] NVS_IDX_DATA_HI = 3'h3;
    localparam logic [2:0] NVS_IDX_CTRL = 3'h4;
    localparam logic [2:0] NVS_IDX_UNLOCK = 3'h5;
    localparam logic [2:0] NVS_IDX_STATUS = 3'h6;
    // Control and status bit positions
    localparam int NVS_B_RD = 0;
    localparam int NVS_B_WR = 1;
    localparam int NVS_B_WRITE_ENABLE_GATE = 2;
    localparam int NVS_B_WRITE_ERROR_FLAG = 3;
    localparam int NVS_B_FREE = 4;
    localparam int NVS_B_LWLO = 5;
    localparam int NVS_B_CONFIG_SPACE_SELECT = 6;
    localparam int NVS_B_PGD = 7;
    localparam int NVS_B_DONE = 0;
    // Unlock pattern and bus answers
    localparam logic [7:0] NVS_KEY1 = 8'h55;
    localparam logic [7:0] NVS_KEY2 = 8'haa;
    localparam logic [1:0] NVS_OKAY = 2'h0;
    localparam logic [1:0] NVS_SLVERR = 2'h2;
    localparam int NVS_AXI_AW = 8;

    typedef enum logic [3:0] {
        NVS_ST_IDLE = 4'b0001,
        NVS_ST_PRD = 4'b0010,
        NVS_ST_SETUP = 4'b0100,
        NVS_ST_BUSY = 4'b1000
    } nvs_fsm_t;

    typedef enum logic [1:0] {
        NVS_UL_IDLE = 2'h0,
        NVS_UL_KEY1 = 2'h1,
        NVS_UL_ARMED = 2'h2
    } nvs_unlock_t;

    typedef enum logic [1:0] {
        NVS_OP_EE = 2'h0,
        NVS_OP_ERASE = 2'h1,
        NVS_OP_LATCH = 2'h2,
        NVS_OP_PROG = 2'h3
    } nvs_op_t;

    typedef struct packed {
        logic awvalid;
        logic [NVS_AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [NVS_AXI_AW-1:0] araddr;
        logic rready;
    } nvs_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } nvs_axi_rsp_t;
endpackage : nvs_pkg

// file: src/nvs_core.sv
// Nonvolatile memory self-access controller with AXI4-Lite register slave
//
// Notes on behaviour
// - EEPROM read: byte lands in data low on the next cycle.
// - Data low keeps a read value until another read, a software write or reset.
// - CPU EEPROM reads ignore the data protect fuse.
// - Write starts only after 55h, AAh, then write start, for every byte.
// - Write start cannot be set while the write enable gate is clear.
// - A started write completes even if the enable gate is cleared.
// - Hardware clears the write enable gate only at reset.
// - End of write clears write start, sets done flag; software clears done.
// - Reset clears enable gate; EEPROM writes refused during power-up timer.
// - Data protect fuse at 0 denies external programmer access.
// - Flash write or erase only outside self-write-protected segments.
// - Flash erases whole 16-word rows aligned on low four address bits.
// - Flash data gathers in 14-bit latches loaded through the data pair.
// - Flash read stalls the second cycle, word held in data pair.
// - CPU flash reads ignore the code protect fuse.
// - Erase: program space, erase select, enable gate, unlock, write start.
// - Erase: two setup cycles then CPU stall about 2 ms.
// - Write start stays set until erase ends; software polls it.
// - Read and write start are set-only; hardware clears them.
// - Program select clear means EEPROM, set means flash; EEPROM after reset.
// - Reset during the busy phase of a write (not its setup cycles) sets the write error flag.
// - Unlock register always reads zero.
`timescale 1ns/10ps
module nvs_core #(
    parameter int PROG_CYCLES = nvs_pkg::NVS_PROG_CYC,
    parameter int PWRT_CYCLES = nvs_pkg::NVS_PWRT_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire nvs_pkg::nvs_axi_req_t axi_i,
    output nvs_pkg::nvs_axi_rsp_t axi_o,
    // Configuration fuses
    input wire logic data_protect_fuse,
    input wire logic code_protect_fuse,
    input wire logic [1:0] self_write_protect,
    // External programmer port
    input wire logic ext_access_req,
    output logic ext_access_grant,
    // CPU stall
    output logic cpu_stall
);
    import nvs_pkg::*;

    typedef struct packed {
        logic aw_have;
        logic [NVS_AXI_AW-1:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_en;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] addr_lo;
        logic [6:0] addr_hi;
        logic [7:0] dat_lo;
        logic [5:0] dat_hi;
        logic rd;
        logic wr;
        logic write_enable_gate;
        logic write_error_flag;
        logic free;
        logic lwlo;
        logic config_space_select;
        logic pgd;
        logic done;
        nvs_unlock_t unlock;
        nvs_fsm_t fsm;
        nvs_op_t op;
        logic [NVS_CNT_W-1:0] cnt;
        logic [NVS_CNT_W-1:0] pwrt;
        logic pwrt_done;
        logic stall;
        logic [3:0] fuse_s1;
        logic [3:0] fuse_s2;
        logic ext_s1;
        logic ext_s2;
        logic ext_grant;
    } nvs_state_t;

    localparam nvs_state_t NVS_RESET = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        unlock: NVS_UL_IDLE, fsm: NVS_ST_IDLE, op: NVS_OP_EE,
        default: '0
    };

    nvs_state_t q;
    nvs_state_t d;
    logic [7:0] ee_mem [NVS_EE_WORDS];
    logic [13:0] pm_mem [2**NVS_PM_AW];
    logic [13:0] latch [NVS_ROW_WORDS];
    logic ee_we;
    logic pm_erase;
    logic pm_prog;
    logic latch_we;
    logic done_set;
    logic [14:0] pm_addr;
    logic [7:0] ctl;

    function automatic logic map_ok(input logic [NVS_AXI_AW-1:0] a);
        map_ok = (a[NVS_AXI_AW-1:5] == '0) && (a[4:2] <= NVS_IDX_STATUS);
    endfunction : map_ok

    function automatic logic wp_blocked(input logic [14:0] a, input logic [1:0] w);
        case (w)
            NVS_WP_NONE: wp_blocked = 1'b0;
            NVS_WP_LOW: wp_blocked = a < NVS_WP_LOW_END;
            NVS_WP_HALF: wp_blocked = a < NVS_WP_HALF_END;
            default: wp_blocked = 1'b1;
        endcase
    endfunction : wp_blocked

    assign pm_addr = {q.addr_hi, q.addr_lo};
    assign ctl = {q.pgd, q.config_space_select, q.lwlo, q.free, q.write_error_flag, q.write_enable_gate, q.wr, q.rd};

    always_comb
    begin
        d = q;
        ee_we = 1'b0;
        pm_erase = 1'b0;
        pm_prog = 1'b0;
        latch_we = 1'b0;
        done_set = 1'b0;
        // Synchronisers for pins
        d.fuse_s1 = {data_protect_fuse, code_protect_fuse, self_write_protect};
        d.fuse_s2 = q.fuse_s1;
        d.ext_s1 = ext_access_req;
        d.ext_s2 = q.ext_s1;
        d.ext_grant = q.ext_s2 & q.fuse_s2[3];
        // Power-up timer
        if (!q.pwrt_done)
        begin
            d.pwrt = q.pwrt + 1'b1;
            d.pwrt_done = q.pwrt == NVS_CNT_W'(PWRT_CYCLES - 1);
        end
        // Write address and data channels, taken in either order
        if (axi_i.awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.aw_addr = axi_i.awaddr;
        end
        if (axi_i.wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.w_data = axi_i.wdata[7:0];
            d.w_en = axi_i.wstrb[0];
        end
        if (q.bvalid && axi_i.bready)
            d.bvalid = 1'b0;
        // Operation sequencer
        case (q.fsm)
            NVS_ST_IDLE: d.cnt = '0;
            NVS_ST_PRD:
            begin
                d.cnt = q.cnt + 1'b1;
                d.stall = q.cnt == '0;
                if (q.cnt == NVS_PRD_STALL)
                begin
                    {d.dat_hi, d.dat_lo} = pm_mem[pm_addr];
                    d.rd = 1'b0;
                    d.fsm = NVS_ST_IDLE;
                end
            end
            NVS_ST_SETUP:
            begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == NVS_SETUP_LAST)
                begin
                    d.cnt = '0;
                    latch_we = (q.op == NVS_OP_LATCH) || (q.op == NVS_OP_PROG);
                    if (q.op == NVS_OP_LATCH)
                    begin
                        d.wr = 1'b0;
                        done_set = 1'b1;
                        d.fsm = NVS_ST_IDLE;
                    end
                    else
                    begin
                        d.stall = q.op != NVS_OP_EE;
                        d.fsm = NVS_ST_BUSY;
                    end
                end
            end
            NVS_ST_BUSY:
            begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == NVS_CNT_W'(PROG_CYCLES - 1))
                begin
                    ee_we = q.op == NVS_OP_EE;
                    pm_erase = q.op == NVS_OP_ERASE;
                    pm_prog = q.op == NVS_OP_PROG;
                    d.wr = 1'b0;
                    done_set = 1'b1;
                    d.stall = 1'b0;
                    d.fsm = NVS_ST_IDLE;
                end
            end
            default: d.fsm = NVS_ST_IDLE;
        endcase
        // Register write, once both halves are held
        if (q.aw_have && q.w_have && !q.bvalid)
        begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = map_ok(q.aw_addr) ? NVS_OKAY : NVS_SLVERR;
            d.unlock = NVS_UL_IDLE;
            if (q.w_en && map_ok(q.aw_addr))
            begin
                case (q.aw_addr[4:2])
                    NVS_IDX_ADDR_LO: d.addr_lo = q.w_data;
                    NVS_IDX_ADDR_HI: d.addr_hi = q.w_data[6:0];
                    NVS_IDX_DATA_LO: d.dat_lo = q.w_data;
                    NVS_IDX_DATA_HI: d.dat_hi = q.w_data[5:0];
                    NVS_IDX_UNLOCK:
                    begin
                        if (q.w_data == NVS_KEY1)
                            d.unlock = NVS_UL_KEY1;
                        else if (q.w_data == NVS_KEY2 && q.unlock == NVS_UL_KEY1)
                            d.unlock = NVS_UL_ARMED;
                    end
                    NVS_IDX_STATUS:
                        if (q.w_data[NVS_B_DONE])
                            d.done = 1'b0;
                    NVS_IDX_CTRL:
                    begin
                        d.write_enable_gate = q.w_data[NVS_B_WRITE_ENABLE_GATE];
                        d.write_error_flag = q.w_data[NVS_B_WRITE_ERROR_FLAG];
                        d.free = q.w_data[NVS_B_FREE];
                        d.lwlo = q.w_data[NVS_B_LWLO];
                        d.config_space_select = q.w_data[NVS_B_CONFIG_SPACE_SELECT];
                        d.pgd = q.w_data[NVS_B_PGD];
                        if (q.w_data[NVS_B_RD] && q.fsm == NVS_ST_IDLE && !q.config_space_select)
                        begin
                            if (!q.pgd)
                                d.dat_lo = ee_mem[q.addr_lo];
                            else
                            begin
                                d.rd = 1'b1;
                                d.fsm = NVS_ST_PRD;
                            end
                        end
                        else if (q.w_data[NVS_B_WR] && q.write_enable_gate && q.unlock == NVS_UL_ARMED
                                 && q.fsm == NVS_ST_IDLE && !q.config_space_select)
                        begin
                            if (!q.pgd && q.pwrt_done)
                            begin
                                d.wr = 1'b1;
                                d.op = NVS_OP_EE;
                                d.fsm = NVS_ST_SETUP;
                            end
                            else if (q.pgd && !wp_blocked(pm_addr, q.fuse_s2[1:0]))
                            begin
                                d.wr = 1'b1;
                                d.fsm = NVS_ST_SETUP;
                                if (q.free)
                                    d.op = NVS_OP_ERASE;
                                else if (q.lwlo)
                                    d.op = NVS_OP_LATCH;
                                else
                                    d.op = NVS_OP_PROG;
                            end
                        end
                    end
                    default: d.bresp = NVS_SLVERR;
                endcase
            end
        end
        // Completion outranks a software clear in the same cycle
        if (done_set)
            d.done = 1'b1;
        d.awready = !d.aw_have;
        d.wready = !d.w_have;
        // Read channel
        if (q.rvalid && axi_i.rready)
        begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        if (axi_i.arvalid && q.arready)
        begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = map_ok(axi_i.araddr) ? NVS_OKAY : NVS_SLVERR;
            case (axi_i.araddr[4:2])
                NVS_IDX_ADDR_LO: d.rdata = q.addr_lo;
                NVS_IDX_ADDR_HI: d.rdata = {1'b0, q.addr_hi};
                NVS_IDX_DATA_LO: d.rdata = q.dat_lo;
                NVS_IDX_DATA_HI: d.rdata = {2'h0, q.dat_hi};
                NVS_IDX_CTRL: d.rdata = ctl;
                NVS_IDX_STATUS:
                    d.rdata = {1'b0, q.fuse_s2, !q.pwrt_done, q.fsm != NVS_ST_IDLE, q.done};
                default: d.rdata = 8'h00;
            endcase
            if (!map_ok(axi_i.araddr))
                d.rdata = 8'h00;
        end
        // Reset clears the gate and flags a write cut short
        if (!aresetn)
        begin
            d = NVS_RESET;
            // Kept through a held reset until software clears it
            if ((q.wr && q.fsm == NVS_ST_BUSY) || q.write_error_flag)
                d.write_error_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        q <= d;
    end

    // Nonvolatile arrays, kept across reset
    always_ff @(posedge aclk)
    begin
        if (ee_we)
            ee_mem[q.addr_lo] <= q.dat_lo;
        for (int i = 0; i < NVS_ROW_WORDS; i++)
        begin
            if (pm_erase)
                pm_mem[{pm_addr[14:NVS_ROW_AW], NVS_ROW_AW'(i)}] <= NVS_ERASED;
            else if (pm_prog)
                pm_mem[{pm_addr[14:NVS_ROW_AW], NVS_ROW_AW'(i)}] <= latch[i];
        end
    end

    // Write latches, reloaded with erased value after programming
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < NVS_ROW_WORDS; i++)
        begin
            if (!aresetn || pm_prog)
                latch[i] <= NVS_ERASED;
            else if (latch_we && q.addr_lo[NVS_ROW_AW-1:0] == NVS_ROW_AW'(i))
                latch[i] <= {q.dat_hi, q.dat_lo};
        end
    end

    assign axi_o = '{
        awready: q.awready, wready: q.wready, bvalid: q.bvalid, bresp: q.bresp,
        arready: q.arready, rvalid: q.rvalid, rdata: {24'h0, q.rdata}, rresp: q.rresp
    };
    assign ext_access_grant = q.ext_grant;
    assign cpu_stall = q.stall;
endmodule : nvs_core

// file: verification/nvs_core_properties.sv
// Port checker for the nonvolatile access controller
`timescale 1ns/10ps
module nvs_core_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire nvs_pkg::nvs_axi_req_t axi_i,
    input wire nvs_pkg::nvs_axi_rsp_t axi_o,
    // External programmer port
    input wire logic data_protect_fuse,
    input wire logic ext_access_req,
    input wire logic ext_access_grant
);
    import nvs_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready;
    endsequence
    sequence s_ar_take;
        axi_i.arvalid && axi_o.arready;
    endsequence
    chk_bresp_hold: assert property (axi_o.bvalid && !axi_i.bready
        |=> axi_o.bvalid && $stable(axi_o.bresp)) else $error("bvalid dropped early");
    chk_rdata_hold: assert property (axi_o.rvalid && !axi_i.rready
        |=> axi_o.rvalid && $stable(axi_o.rdata)) else $error("rvalid dropped early");
    chk_rdata_byte: assert property (axi_o.rvalid |-> axi_o.rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_unlock_zero: assert property (s_ar_take ##0 (axi_i.araddr == 8'h14)
        |=> axi_o.rvalid && axi_o.rdata == 32'h0) else $error("unlock reads nonzero");
    chk_unmapped_err: assert property (s_ar_take ##0 (axi_i.araddr > 8'h18)
        |=> axi_o.rvalid && axi_o.rresp == NVS_SLVERR) else $error("no error on hole");
    chk_write_resp: assert property (s_wr_take
        |=> !axi_o.awready ##[0:1] axi_o.bvalid) else $error("write answer late");
    chk_ar_busy: assert property (axi_o.rvalid |-> !axi_o.arready)
        else $error("arready during read answer");
    chk_grant_deny: assert property ((!data_protect_fuse) [*6] |-> !ext_access_grant)
        else $error("grant while protected");
    chk_grant_allow: assert property ((data_protect_fuse && ext_access_req) [*6]
        |-> ext_access_grant) else $error("grant missing");
    chk_grant_idle: assert property ((!ext_access_req) [*6] |-> !ext_access_grant)
        else $error("grant without request");
endmodule : nvs_core_properties

// file: verification/nvs_cpu_model.sv
// Software side model: AXI4-Lite master issuing register accesses
`timescale 1ns/10ps
module nvs_cpu_model (
    // Clock
    input wire logic aclk,
    // Register bus
    input wire nvs_pkg::nvs_axi_rsp_t axi_o,
    output nvs_pkg::nvs_axi_req_t axi_i
);
    import nvs_pkg::*;
    initial axi_i = '0;
    // One transfer at a time, strobe followed by idle bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] ok;
        ok = 2'b00;
        @(posedge aclk);
        axi_i.awvalid <= 1'b1;
        axi_i.awaddr <= a;
        axi_i.wvalid <= 1'b1;
        axi_i.wdata <= d;
        axi_i.wstrb <= 4'hf;
        axi_i.bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (axi_o.awready === 1'b1)
            begin
                ok[0] = 1'b1;
                axi_i.awvalid <= 1'b0;
            end
            if (axi_o.wready === 1'b1)
            begin
                ok[1] = 1'b1;
                axi_i.wvalid <= 1'b0;
            end
        end while (ok != 2'b11);
        while (axi_o.bvalid !== 1'b1) @(posedge aclk);
        axi_i.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        axi_i.arvalid <= 1'b1;
        axi_i.araddr <= a;
        axi_i.rready <= 1'b1;
        do @(posedge aclk); while (axi_o.arready !== 1'b1);
        axi_i.arvalid <= 1'b0;
        while (axi_o.rvalid !== 1'b1) @(posedge aclk);
        d = axi_o.rdata;
        axi_i.rready <= 1'b0;
    endtask : rd
    // Keys back to back with nothing between
    task automatic ul;
        wr(8'h14, 32'h55);
        wr(8'h14, 32'haa);
    endtask : ul
endmodule : nvs_cpu_model

// file: verification/nvs_core_bench.sv
// Self-checking testbench for the nonvolatile access controller
`timescale 1ns/10ps
module nvs_core_bench;
    import nvs_pkg::*;
    localparam int PC = 20;
    localparam int PW = 50;
    logic aclk;
    logic aresetn;
    nvs_axi_req_t axi_i;
    nvs_axi_rsp_t axi_o;
    logic dpf;
    logic cpf;
    logic [1:0] swp;
    logic ereq;
    logic grant;
    logic stall;
    int miscompares = 0;
    int checked = 0;
    int stalls = 0;
    nvs_core #(.PROG_CYCLES(PC), .PWRT_CYCLES(PW)) dut (.aclk(aclk), .aresetn(aresetn),
        .axi_i(axi_i), .axi_o(axi_o), .data_protect_fuse(dpf), .code_protect_fuse(cpf),
        .self_write_protect(swp), .ext_access_req(ereq), .ext_access_grant(grant),
        .cpu_stall(stall));
    nvs_cpu_model cpu (.aclk(aclk), .axi_o(axi_o), .axi_i(axi_i));
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) if (stall === 1'b1) stalls <= stalls + 1;
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        cpu.rd(a, v);
        chk($sformatf("reg %h", a), v, e);
    endtask : rd
    task automatic go(input logic [31:0] c);
        cpu.ul();
        cpu.wr(8'h10, c);
    endtask : go
    task automatic wdone;
        logic [31:0] v;
        int i;
        i = 0;
        v = 32'h0;
        while (v[0] !== 1'b1 && i < 100)
        begin
            cpu.rd(8'h18, v);
            i++;
        end
        chk("done", 32'(v[0]), 32'h1);
        cpu.wr(8'h18, 32'h1);
        cpu.rd(8'h18, v);
        chk("done_clear", 32'(v[0]), 32'h0);
    endtask : wdone
    task automatic fr(input logic [7:0] lo, input logic [13:0] e);
        cpu.wr(8'h00, {24'h0, lo});
        cpu.wr(8'h10, 32'h81);
        rd(8'h08, {24'h0, e[7:0]});
        rd(8'h0c, {26'h0, e[13:8]});
    endtask : fr
    task automatic t_boot;
        logic [31:0] v;
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h1c, 32'h0);
        cpu.rd(8'h18, v);
        chk("timer_on", 32'(v[2]), 32'h1);
        cpu.wr(8'h10, 32'h4);
        go(32'h6);
        rd(8'h10, 32'h4);
        repeat (PW) @(posedge aclk);
        cpu.rd(8'h18, v);
        chk("timer_off", 32'(v[2]), 32'h0);
    endtask : t_boot
    task automatic t_refuse;
        cpu.wr(8'h10, 32'h0);
        go(32'h2);
        rd(8'h10, 32'h0);
        cpu.wr(8'h10, 32'h4);
        cpu.wr(8'h14, 32'haa);
        cpu.wr(8'h14, 32'h55);
        cpu.wr(8'h10, 32'h6);
        rd(8'h10, 32'h4);
        cpu.wr(8'h14, 32'h55);
        cpu.wr(8'h08, 32'h1);
        cpu.wr(8'h14, 32'haa);
        cpu.wr(8'h10, 32'h6);
        rd(8'h10, 32'h4);
    endtask : t_refuse
    task automatic t_ee;
        cpu.wr(8'h00, 32'h5);
        cpu.wr(8'h08, 32'h3c);
        go(32'h6);
        rd(8'h10, 32'h6);
        cpu.wr(8'h10, 32'h0);
        wdone();
        rd(8'h10, 32'h0);
        cpu.wr(8'h08, 32'h0);
        cpu.wr(8'h10, 32'h1);
        rd(8'h08, 32'h3c);
        rd(8'h08, 32'h3c);
        rd(8'h10, 32'h0);
        cpu.wr(8'h10, 32'h4);
        cpu.wr(8'h08, 32'h5a);
        go(32'h6);
        wdone();
        rd(8'h10, 32'h4);
        cpu.wr(8'h10, 32'h6);
        rd(8'h10, 32'h4);
    endtask : t_ee
    task automatic t_flash;
        int s0;
        cpu.wr(8'h04, 32'h1);
        cpu.wr(8'h00, 32'h23);
        cpu.wr(8'h10, 32'h94);
        s0 = stalls;
        go(32'h96);
        rd(8'h10, 32'h96);
        wdone();
        chk("stall", 32'((stalls - s0) >= PC && (stalls - s0) <= PC + 2), 32'h1);
        rd(8'h10, 32'h94);
        cpf <= 1'b1;
        fr(8'h2f, 14'h3fff);
        cpu.wr(8'h00, 32'h21);
        cpu.wr(8'h08, 32'h34);
        cpu.wr(8'h0c, 32'h12);
        cpu.wr(8'h10, 32'ha4);
        go(32'ha6);
        wdone();
        cpu.wr(8'h00, 32'h22);
        cpu.wr(8'h08, 32'hbc);
        cpu.wr(8'h0c, 32'h0a);
        cpu.wr(8'h10, 32'h84);
        go(32'h86);
        wdone();
        fr(8'h21, 14'h1234);
        fr(8'h22, 14'h0abc);
        fr(8'h20, 14'h3fff);
        swp <= 2'b10;
        cpu.wr(8'h00, 32'h0);
        cpu.wr(8'h10, 32'h94);
        go(32'h96);
        rd(8'h10, 32'h94);
    endtask : t_flash
    task automatic t_ext;
        ereq <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("grant_off", 32'(grant), 32'h0);
        dpf <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("grant_on", 32'(grant), 32'h1);
        ereq <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : t_ext
    task automatic t_werr;
        cpu.wr(8'h00, 32'h7);
        cpu.wr(8'h10, 32'h4);
        go(32'h6);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h10, 32'h8);
    endtask : t_werr
    initial
    begin
        aresetn = 1'b0;
        dpf = 1'b0;
        cpf = 1'b0;
        swp = 2'b11;
        ereq = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_boot();
        t_refuse();
        t_ee();
        t_flash();
        t_ext();
        t_werr();
        tally_and_finish();
    end
    initial
    begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        tally_and_finish();
    end
endmodule : nvs_core_bench
bind nvs_core nvs_core_properties u_props (.aclk(aclk), .aresetn(aresetn), .axi_i(axi_i),
    .axi_o(axi_o), .data_protect_fuse(data_protect_fuse), .ext_access_req(ext_access_req),
    .ext_access_grant(ext_access_grant));
